// ===== core/i2cs_bus_if.sv
`timescale 1ns/100ps
`default_nettype none

// Open-drain two-wire bus; a line is low while any enabled driver pulls it
interface i2cs_bus_if;
    logic scl;
    logic sda;
    logic mSclOut;
    logic mSclOe;
    logic mSdaOut;
    logic mSdaOe;
    logic devSdaOut;
    logic devSdaOe;

    assign scl = ~(mSclOe & ~mSclOut);
    assign sda = ~((mSdaOe & ~mSdaOut) | (devSdaOe & ~devSdaOut));

    modport device (
        input scl,
        input sda,
        output devSdaOut,
        output devSdaOe
    );

    modport master (
        input sda,
        output mSclOut,
        output mSclOe,
        output mSdaOut,
        output mSdaOe
    );
endinterface : i2cs_bus_if

`default_nettype wire

// ===== core/i2cs_device_end.sv
`timescale 1ns/100ps
`default_nettype none

module i2cs_device_end (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    i2cs_bus_if.device bus,
    input wire logic adrSel,
    input wire logic spikeFilterOffPin,
    output logic wrStrobe,
    output logic [11:0] wrAddr,
    output logic [i2cs_pkg::WORD_W-1:0] wrWord,
    output logic [2:0] wrLen,
    output logic [11:0] rdAddr,
    output logic rdStrobe,
    input wire logic [i2cs_pkg::WORD_W-1:0] rdWord,
    output logic busy
);
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_RX = 5'h02,
        ST_ACKOUT = 5'h04,
        ST_TX = 5'h08,
        ST_ACKIN = 5'h10
    } i2cs_dst_type;

    typedef enum logic [4:0] {
        PH_ADDR = 5'h01,
        PH_SUBH = 5'h02,
        PH_SUBL = 5'h04,
        PH_WDATA = 5'h08,
        PH_RDATA = 5'h10
    } i2cs_phase_type;

    typedef struct packed {
        logic [1:0] adrSync;
        i2cs_dst_type st;
        i2cs_phase_type ph;
        logic [3:0] bitCnt;
        logic [7:0] shreg;
        logic [7:0] subHi;
        logic [i2cs_pkg::WORD_W-1:0] word;
        logic [2:0] byteIdx;
        logic [11:0] subAddr;
        logic isRead;
        logic pastEnd;
        logic sclPrev;
        logic sdaPrev;
        logic sdaOe;
        logic sdaOut;
        logic wrStrobe;
        logic [11:0] wrAddr;
        logic [i2cs_pkg::WORD_W-1:0] wrWord;
        logic [2:0] wrLen;
        logic rdStrobe;
    } i2cs_dev_type;

    i2cs_dev_type q;
    i2cs_dev_type d;
    logic sclF;
    logic sdaF;

    ////////////////////////////////////////////////////////////////////////////////
    // Synchronised and deglitched bus lines

    i2cs_line_filter sclFilter (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .lineIn(bus.scl),
        .filterOff(spikeFilterOffPin),
        .lineOut(sclF)
    );

    i2cs_line_filter sdaFilter (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .lineIn(bus.sda),
        .filterOff(spikeFilterOffPin),
        .lineOut(sdaF)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Protocol engine

    always_comb
    begin
        logic sclRise;
        logic sclFall;
        logic startSeen;
        logic stopSeen;
        logic ack;
        logic [2:0] lenNow;
        logic [11:0] newSub;
        logic [5:0] shAmt;
        logic [i2cs_pkg::WORD_W-1:0] loadWord;
        sclRise = sclF & ~q.sclPrev;
        sclFall = ~sclF & q.sclPrev;
        startSeen = sclF & q.sclPrev & q.sdaPrev & ~sdaF;
        stopSeen = sclF & q.sclPrev & ~q.sdaPrev & sdaF;
        ack = 1'b0;
        lenNow = i2cs_pkg::wordLen(q.subAddr, q.isRead);
        newSub = {q.subHi[3:0], q.shreg};
        shAmt = {3'(3'h5 - lenNow), 3'h0};
        // Fetch a fresh word only at a word boundary; left-align it
        loadWord = (q.byteIdx == 3'h0) ? (rdWord << shAmt) : q.word;

        d = q;
        d.wrStrobe = 1'b0;
        d.rdStrobe = 1'b0;
        d.adrSync = {q.adrSync[0], adrSel};
        d.sclPrev = sclF;
        d.sdaPrev = sdaF;

        if (startSeen)
        begin
            d.st = ST_RX;
            d.ph = PH_ADDR;
            d.bitCnt = 4'h0;
            d.sdaOe = 1'b0;
        end
        else if (stopSeen)
        begin
            // Any partial word is dropped here
            d.st = ST_IDLE;
            d.sdaOe = 1'b0;
        end
        else
        begin
            case (q.st)
                ST_IDLE:
                begin
                    d.sdaOe = 1'b0;
                end
                ST_RX:
                begin
                    if (sclRise)
                    begin
                        d.shreg = {q.shreg[6:0], sdaF};
                        d.bitCnt = 4'(q.bitCnt + 4'h1);
                    end
                    else if (sclFall && q.bitCnt == 4'h8)
                    begin
                        case (q.ph)
                            PH_ADDR:
                            begin
                                if (q.shreg[7:1] == {i2cs_pkg::DEV_ADDR_HI, q.adrSync[1]})
                                begin
                                    ack = 1'b1;
                                    d.isRead = q.shreg[0];
                                    d.ph = q.shreg[0] ? PH_RDATA : PH_SUBH;
                                    d.byteIdx = 3'h0;
                                end
                            end
                            PH_SUBH:
                            begin
                                ack = 1'b1;
                                d.subHi = q.shreg;
                                d.ph = PH_SUBL;
                            end
                            PH_SUBL:
                            begin
                                if (q.subHi[7:4] == 4'h0 && newSub <= i2cs_pkg::SUB_MAX
                                    && i2cs_pkg::wordLen(newSub, 1'b0) != 3'h0)
                                begin
                                    ack = 1'b1;
                                    d.subAddr = newSub;
                                    d.ph = PH_WDATA;
                                    d.byteIdx = 3'h0;
                                    d.pastEnd = 1'b0;
                                end
                            end
                            PH_WDATA:
                            begin
                                if (!q.pastEnd)
                                begin
                                    ack = 1'b1;
                                    d.word = {q.word[i2cs_pkg::WORD_W-9:0], q.shreg};
                                    if (3'(q.byteIdx + 3'h1) == lenNow)
                                    begin
                                        d.wrStrobe = 1'b1;
                                        d.wrAddr = q.subAddr;
                                        d.wrWord = {q.word[i2cs_pkg::WORD_W-9:0], q.shreg};
                                        d.wrLen = lenNow;
                                        d.byteIdx = 3'h0;
                                        if (q.subAddr == i2cs_pkg::SUB_MAX)
                                            d.pastEnd = 1'b1;
                                        else
                                            d.subAddr = 12'(q.subAddr + 12'h1);
                                    end
                                    else
                                        d.byteIdx = 3'(q.byteIdx + 3'h1);
                                end
                            end
                            default:
                            begin
                                ack = 1'b0;
                            end
                        endcase
                        d.st = ack ? ST_ACKOUT : ST_IDLE;
                        d.sdaOe = ack;
                    end
                end
                ST_ACKOUT:
                begin
                    if (sclFall)
                    begin
                        d.bitCnt = 4'h0;
                        if (q.ph == PH_RDATA)
                        begin
                            d.word = loadWord << 8;
                            d.shreg = loadWord[i2cs_pkg::WORD_W-1 -: 8];
                            d.sdaOe = ~loadWord[i2cs_pkg::WORD_W-1];
                            d.rdStrobe = (q.byteIdx == 3'h0);
                            d.st = ST_TX;
                        end
                        else
                        begin
                            d.sdaOe = 1'b0;
                            d.st = ST_RX;
                        end
                    end
                end
                ST_TX:
                begin
                    if (sclRise)
                        d.bitCnt = 4'(q.bitCnt + 4'h1);
                    else if (sclFall)
                    begin
                        if (q.bitCnt == 4'h8)
                        begin
                            d.sdaOe = 1'b0;
                            d.st = ST_ACKIN;
                        end
                        else
                        begin
                            d.shreg = {q.shreg[6:0], 1'b0};
                            d.sdaOe = ~q.shreg[6];
                        end
                    end
                end
                ST_ACKIN:
                begin
                    if (sclRise)
                    begin
                        if (sdaF)
                            d.st = ST_IDLE;
                        else if (3'(q.byteIdx + 3'h1) == lenNow)
                        begin
                            d.byteIdx = 3'h0;
                            // Past the top the last location keeps being returned
                            if (q.subAddr != i2cs_pkg::SUB_MAX)
                                d.subAddr = 12'(q.subAddr + 12'h1);
                        end
                        else
                            d.byteIdx = 3'(q.byteIdx + 3'h1);
                    end
                    else if (sclFall)
                    begin
                        d.bitCnt = 4'h0;
                        d.word = loadWord << 8;
                        d.shreg = loadWord[i2cs_pkg::WORD_W-1 -: 8];
                        d.sdaOe = ~loadWord[i2cs_pkg::WORD_W-1];
                        d.rdStrobe = (q.byteIdx == 3'h0);
                        d.st = ST_TX;
                    end
                end
                default:
                begin
                    d.st = ST_IDLE;
                    d.sdaOe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            q <= '0;
            q.st <= ST_IDLE;
            q.ph <= PH_ADDR;
            q.sclPrev <= 1'b1;
            q.sdaPrev <= 1'b1;
        end
        else if (ce)
            q <= d;
    end

    assign bus.devSdaOut = q.sdaOut;
    assign bus.devSdaOe = q.sdaOe;
    assign wrStrobe = q.wrStrobe;
    assign wrAddr = q.wrAddr;
    assign wrWord = q.wrWord;
    assign wrLen = q.wrLen;
    assign rdAddr = q.subAddr;
    assign rdStrobe = q.rdStrobe;
    assign busy = ~q.st[0];
endmodule : i2cs_device_end

`default_nettype wire

// ===== core/i2cs_line_filter.sv
`timescale 1ns/100ps
`default_nettype none

module i2cs_line_filter #(
    parameter int FILT_CYC = i2cs_pkg::FILT_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic lineIn,
    input wire logic filterOff,
    output logic lineOut
);
    typedef struct packed {
        logic [1:0] sync;
        logic [1:0] offSync;
        logic out;
        logic [3:0] cnt;
    } i2cs_filt_type;

    i2cs_filt_type q;
    i2cs_filt_type d;

    always_comb
    begin
        d = q;
        d.sync = {q.sync[0], lineIn};
        d.offSync = {q.offSync[0], filterOff};
        if (q.offSync[1])
        begin
            d.out = q.sync[1];
            d.cnt = 4'h0;
        end
        else if (q.sync[1] == q.out)
            d.cnt = 4'h0;
        // A pulse under the limit spans at most FILT_CYC samples; demand one more
        else if (q.cnt == 4'(FILT_CYC))
        begin
            d.out = q.sync[1];
            d.cnt = 4'h0;
        end
        else
            d.cnt = 4'(q.cnt + 4'h1);
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            q <= '1;
        else if (ce)
            q <= d;
    end

    assign lineOut = q.out;
endmodule : i2cs_line_filter

`default_nettype wire

// ===== core/i2cs_master_end.sv
`timescale 1ns/100ps
`default_nettype none

module i2cs_master_end #(
    parameter int TICK_CYC = i2cs_pkg::MASTER_TICK_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    i2cs_bus_if.master bus,
    input wire logic cmdValid,
    input wire i2cs_pkg::i2cs_cmd_type cmdKind,
    input wire logic [7:0] cmdData,
    input wire logic cmdNack,
    output logic cmdReady,
    output logic done,
    output logic [7:0] rdData,
    output logic ackRcvd
);
    typedef enum logic [3:0] {
        MS_IDLE = 4'h1,
        MS_START = 4'h2,
        MS_BITS = 4'h4,
        MS_STOP = 4'h8
    } i2cs_mst_type;

    typedef struct packed {
        logic [1:0] sdaSync;
        i2cs_mst_type st;
        logic [1:0] step;
        logic [7:0] div;
        logic [3:0] bitIdx;
        logic [8:0] tx;
        logic [8:0] rx;
        logic sclHigh;
        logic sdaHigh;
        logic ready;
        logic done;
        logic [7:0] rdData;
        logic ackRcvd;
    } i2cs_mstate_type;

    i2cs_mstate_type q;
    i2cs_mstate_type d;

    ////////////////////////////////////////////////////////////////////////////////
    // Four ticks per phase: set data, raise clock, sample or change, lower clock (left high after a stop)

    always_comb
    begin
        logic tick;
        tick = (q.div == 8'(TICK_CYC - 1));
        d = q;
        d.done = 1'b0;
        d.sdaSync = {q.sdaSync[0], bus.sda};
        d.div = tick ? 8'h0 : 8'(q.div + 8'h1);
        case (q.st)
            MS_IDLE:
            begin
                d.div = 8'h0;
                if (cmdValid)
                begin
                    d.ready = 1'b0;
                    d.step = 2'h0;
                    d.bitIdx = 4'h0;
                    case (cmdKind)
                        i2cs_pkg::CMD_START: d.st = MS_START;
                        i2cs_pkg::CMD_STOP: d.st = MS_STOP;
                        i2cs_pkg::CMD_WRITE:
                        begin
                            d.tx = {cmdData, 1'b1};
                            d.st = MS_BITS;
                        end
                        default:
                        begin
                            d.tx = {8'hff, cmdNack};
                            d.st = MS_BITS;
                        end
                    endcase
                end
            end
            MS_START, MS_STOP, MS_BITS:
            begin
                if (tick)
                begin
                    d.step = 2'(q.step + 2'h1);
                    case (q.step)
                        2'h0: d.sdaHigh = (q.st == MS_START) | ((q.st == MS_BITS) & q.tx[8]);
                        2'h1: d.sclHigh = 1'b1;
                        2'h2:
                        begin
                            // One condition per clock-high interval
                            if (q.st == MS_BITS)
                                d.rx = {q.rx[7:0], q.sdaSync[1]};
                            else
                                d.sdaHigh = (q.st == MS_STOP);
                        end
                        default:
                        begin
                            d.sclHigh = (q.st == MS_STOP);
                            d.tx = {q.tx[7:0], 1'b1};
                            d.bitIdx = 4'(q.bitIdx + 4'h1);
                            if (q.st != MS_BITS || q.bitIdx == 4'h8)
                            begin
                                d.st = MS_IDLE;
                                d.ready = 1'b1;
                                d.done = 1'b1;
                                if (q.st == MS_BITS)
                                begin
                                    d.rdData = q.rx[8:1];
                                    d.ackRcvd = ~q.rx[0];
                                end
                            end
                        end
                    endcase
                end
            end
            default:
            begin
                d.st = MS_IDLE;
                d.ready = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            q <= '0;
            q.st <= MS_IDLE;
            q.sclHigh <= 1'b1;
            q.sdaHigh <= 1'b1;
            q.ready <= 1'b1;
            q.sdaSync <= 2'h3;
        end
        else if (ce)
            q <= d;
    end

    assign bus.mSclOut = 1'b0;
    assign bus.mSclOe = ~q.sclHigh;
    assign bus.mSdaOut = 1'b0;
    assign bus.mSdaOe = ~q.sdaHigh;
    assign cmdReady = q.ready;
    assign done = q.done;
    assign rdData = q.rdData;
    assign ackRcvd = q.ackRcvd;
endmodule : i2cs_master_end

`default_nettype wire

// ===== core/i2cs_pkg.sv
package i2cs_pkg;

    // Link sampling and filtering
    localparam int CLK_NS = 8;
    localparam int FILT_NS = 50;
    localparam int FILT_CYC = (FILT_NS + CLK_NS - 1) / CLK_NS;
    localparam int MASTER_TICK_CYC = 8;

    // Slave address: upper six bits fixed, lowest bit from the select pin
    localparam logic [5:0] DEV_ADDR_HI = 6'h0a;

    // Subaddress map
    localparam logic [11:0] SUB_PROG_BASE = 12'h400;
    localparam logic [11:0] SUB_SLEW_BASE = 12'ha00;
    localparam logic [11:0] SUB_SLIND_BASE = 12'ha45;
    localparam logic [11:0] SUB_CAPT_BASE = 12'ha4a;
    localparam logic [11:0] SUB_CAPO_BASE = 12'ha50;
    localparam logic [11:0] SUB_RAMCFG = 12'ha53;
    localparam logic [11:0] SUB_SERIN = 12'ha56;
    localparam logic [11:0] SUB_MAX = 12'ha56;

    localparam int WORD_BYTES_MAX = 5;
    localparam int WORD_W = 8 * WORD_BYTES_MAX;

    typedef enum logic [1:0] {
        CMD_START = 2'h0,
        CMD_STOP = 2'h1,
        CMD_WRITE = 2'h2,
        CMD_READ = 2'h3
    } i2cs_cmd_type;

    // Bytes per word at a subaddress; zero marks an invalid location
    function automatic logic [2:0] wordLen(input logic [11:0] a, input logic rd);
        logic [2:0] n;
        n = 3'h0;
        if (a < SUB_PROG_BASE)
            n = 3'h4;
        else if (a < SUB_SLIND_BASE)
            n = 3'h5;
        else if (a < SUB_CAPT_BASE)
            n = 3'h2;
        else if (a < SUB_CAPO_BASE)
            n = rd ? 3'h3 : 3'h2;
        else if (a < SUB_RAMCFG)
            n = 3'h2;
        else if (a == SUB_RAMCFG || a == SUB_SERIN)
            n = 3'h1;
        else if (a < SUB_SERIN)
            n = 3'h2;
        return n;
    endfunction : wordLen

endpackage : i2cs_pkg

// ===== test/i2cs_bus_properties.sv
`timescale 1ns/100ps
`default_nettype none

module i2cs_bus_properties (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic adrSel,
    input wire logic scl,
    input wire logic sda,
    input wire logic devSdaOut,
    input wire logic devSdaOe
);
    logic sclQ, sdaQ, addrW, addrR;
    logic [3:0] bitCnt;
    logic [2:0] byteCnt;
    logic [7:0] shiftQ, subHQ;
    wire logic rise = scl & ~sclQ;
    wire logic ninth = rise & (bitCnt == 4'h8);
    wire logic [7:0] wAdr = adrSel ? 8'h2a : 8'h28;
    wire logic subOk = (subHQ[7:4] == 4'h0) && ({subHQ[3:0], shiftQ} <= 12'ha56);

    ////////////////////////////////////////////////////////////////////////
    // Byte tracker on the wire, restarted by every start
    always_ff @(posedge clk)
    begin
        sclQ <= scl;
        sdaQ <= sda;
        if (!rst_n || (scl && sclQ && sdaQ && !sda))
        begin
            bitCnt <= 4'h0;
            byteCnt <= 3'h0;
            addrW <= 1'b0;
            addrR <= 1'b0;
        end
        else if (ninth)
        begin
            bitCnt <= 4'h0;
            byteCnt <= (byteCnt == 3'h7) ? byteCnt : byteCnt + 3'h1;
            if (byteCnt == 3'h0)
            begin
                addrW <= shiftQ == wAdr;
                addrR <= shiftQ == (wAdr | 8'h01);
            end
            if (byteCnt == 3'h1)
                subHQ <= shiftQ;
        end
        else if (rise)
        begin
            bitCnt <= bitCnt + 4'h1;
            shiftQ <= {shiftQ[6:0], sda};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    property p_addr_ack; ninth && byteCnt == 3'h0 |-> devSdaOe == (shiftQ[7:1] == wAdr[7:1]); endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("address ack wrong");
    property p_subh_ack; ninth && byteCnt == 3'h1 && addrW |-> devSdaOe; endproperty
    a_subh_ack: assert property (p_subh_ack) else $error("subaddress high not acked");
    property p_subl_ack; ninth && byteCnt == 3'h2 && addrW |-> devSdaOe == subOk; endproperty
    a_subl_ack: assert property (p_subl_ack) else $error("subaddress ack wrong");
    property p_master_ack; ninth && byteCnt != 3'h0 && addrR |-> !devSdaOe; endproperty
    a_master_ack: assert property (p_master_ack) else $error("slave drove ack slot");
    property p_quiet; rise && bitCnt != 4'h8 && !(addrR && byteCnt != 3'h0) |-> !devSdaOe; endproperty
    a_quiet: assert property (p_quiet) else $error("slave drove a written bit");
    property p_unmatched; ninth && byteCnt != 3'h0 && !addrW && !addrR |-> !devSdaOe; endproperty
    a_unmatched: assert property (p_unmatched) else $error("unaddressed slave acked");
    property p_low_edge; $changed(devSdaOe) |-> !scl; endproperty
    a_low_edge: assert property (p_low_edge) else $error("slave moved data line, clock high");
    property p_drive_len; $rose(devSdaOe) |-> ##[1:400] !devSdaOe; endproperty
    a_drive_len: assert property (p_drive_len) else $error("slave holds data line");

    cover property (ninth && byteCnt == 3'h2 && addrW && !subOk);
    cover property (ninth && addrR && byteCnt == 3'h7);
    cover property (ninth && byteCnt == 3'h0 && !devSdaOe);
endmodule : i2cs_bus_properties

`default_nettype wire

// ===== test/test_i2c_slave_control_port.sv
`timescale 1ns/100ps
`default_nettype none

module test_i2c_slave_control_port;
    logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, adrSel = 1'b0, filtOff = 1'b0;
    logic cmdValid = 1'b0, cmdNack = 1'b0, cmdReady, done, ackRcvd, wrStrobe, rdStrobe, busy;
    logic [7:0] cmdData = 8'h00, rdData, wAdr = 8'h28;
    logic [11:0] wrAddr, rdAddr;
    logic [2:0] wrLen;
    logic [39:0] wrWord, rdWord = 40'h0;
    i2cs_pkg::i2cs_cmd_type cmdKind = i2cs_pkg::CMD_START;
    int errors = 0, checkCount = 0;
    logic [54:0] seenQ[$];

    i2cs_bus_if bus();
    i2cs_device_end i_i2cs_device_end (.clk(clk), .rst_n(rst_n), .ce(ce), .bus(bus),
        .adrSel(adrSel), .spikeFilterOffPin(filtOff), .wrStrobe(wrStrobe), .wrAddr(wrAddr),
        .wrWord(wrWord), .wrLen(wrLen), .rdAddr(rdAddr), .rdStrobe(rdStrobe),
        .rdWord(rdWord), .busy(busy));
    i2cs_master_end i_i2cs_master_end (.clk(clk), .rst_n(rst_n), .ce(ce), .bus(bus),
        .cmdValid(cmdValid), .cmdKind(cmdKind), .cmdData(cmdData), .cmdNack(cmdNack),
        .cmdReady(cmdReady), .done(done), .rdData(rdData), .ackRcvd(ackRcvd));
    i2cs_bus_properties i_i2cs_bus_properties (.clk(clk), .rst_n(rst_n), .adrSel(adrSel),
        .scl(bus.scl), .sda(bus.sda), .devSdaOut(bus.devSdaOut), .devSdaOe(bus.devSdaOe));

    function automatic logic [39:0] mask(input logic [2:0] n);
        return (40'h1 << (8 * n)) - 40'h1;
    endfunction : mask
    // Distinct bytes so a swapped byte order shows
    function automatic logic [39:0] memWord(input logic [11:0] a);
        return {a[7:0], a[7:0] ^ 8'h5a, a[7:0] ^ 8'h3c, a[7:0] ^ 8'hc3, a[7:0] ^ 8'h99};
    endfunction : memWord
    function automatic logic [2:0] expLen(input logic [11:0] a);
        if (a < 12'h400)
            return 3'h4;
        if (a < 12'ha45)
            return 3'h5;
        return (a == 12'ha53 || a == 12'ha56) ? 3'h1 : 3'h2;
    endfunction : expLen

    task automatic check(input string what, input logic [54:0] seen, input logic [54:0] exp);
        checkCount++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wrap_up;
        $display("Checks %0d, mismatches %0d", checkCount, errors);
        if (errors == 0 && checkCount > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : wrap_up
    task automatic cmd(input i2cs_pkg::i2cs_cmd_type k, input logic [7:0] d, input logic nk);
        int n;
        n = 0;
        @(negedge clk);
        cmdKind = k;
        cmdData = d;
        cmdNack = nk;
        cmdValid = 1'b1;
        @(negedge clk);
        cmdValid = 1'b0;
        do
        begin
            @(posedge clk);
            #1;
            n++;
        end
        while (done !== 1'b1 && n < 600);
        if (n >= 600)
        begin
            errors++;
            wrap_up();
        end
    endtask : cmd
    task automatic wr(input logic [7:0] b, input logic ack);
        cmd(i2cs_pkg::CMD_WRITE, b, 1'b0);
        check("ack", ackRcvd, ack);
    endtask : wr
    task automatic head(input logic [15:0] s, input logic ok);
        cmd(i2cs_pkg::CMD_START, 8'h00, 1'b0);
        wr(wAdr, 1'b1);
        wr(s[15:8], 1'b1);
        wr(s[7:0], ok);
    endtask : head
    task automatic stop;
        cmd(i2cs_pkg::CMD_STOP, 8'h00, 1'b0);
        repeat (16) @(negedge clk);
        check("idle", {busy, bus.scl, bus.sda}, 3'b011);
    endtask : stop

    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk)
        if (wrStrobe === 1'b1)
            seenQ.push_back({wrAddr, wrLen, wrWord & mask(wrLen)});
    always @(negedge clk)
        rdWord <= memWord(rdAddr);
    initial
    begin
        forever #4 clk = ~clk;
    end

    initial
    begin
        logic [11:0] a;
        logic [39:0] w;
        logic [2:0] n;
        int idx;
        logic [11:0] st[6];
        logic [15:0] bad[3];
        void'($urandom(75));
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        for (int p = 0; p < 2; p++)
        begin
            adrSel = p[0];
            filtOff = p[0];
            wAdr = p[0] ? 8'h2a : 8'h28;
            repeat (16) @(negedge clk);
            cmd(i2cs_pkg::CMD_START, 8'h00, 1'b0);
            wr(wAdr ^ 8'h02, 1'b0);
            wr(8'h0a, 1'b0);
            stop();
            bad = '{16'h0a57, 16'h0fff, 16'h1000 | 16'($urandom % 2647)};
            foreach (bad[i])
            begin
                head(bad[i], 1'b0);
                stop();
            end
            st = '{12'h3ff, 12'h9ff, 12'ha53, 12'ha55, 12'($urandom % 1024),
                12'h400 + 12'($urandom % 1535)};
            foreach (st[i])
            begin
                a = st[i];
                head({4'h0, a}, 1'b1);
                for (int k = 0; k < 2; k++)
                begin
                    n = expLen(a);
                    w = 40'({$urandom, $urandom}) & mask(n);
                    for (int j = int'(n) - 1; j >= 0; j--)
                        wr(w[8 * j +: 8], 1'b1);
                    check("word", seenQ.size() ? seenQ.pop_front() : 55'h0, {a, n, w});
                    a = a + 12'h1;
                end
                if (a == 12'ha57)
                    wr(8'($urandom), 1'b0);
                stop();
                check("extra", 55'(seenQ.size()), 55'h0);
            end
            // Partial word cut by a repeated start must leave no store
            head({4'h0, st[4]}, 1'b1);
            wr(8'($urandom), 1'b1);
            cmd(i2cs_pkg::CMD_START, 8'h00, 1'b0);
            wr(wAdr, 1'b1);
            stop();
            check("abort", 55'(seenQ.size()), 55'h0);
            st = '{12'h3ff, 12'h9fe, 12'ha55, 12'h0, 12'h0, 12'h0};
            for (int i = 0; i < 3; i++)
            begin
                a = st[i];
                idx = 0;
                head({4'h0, a}, 1'b1);
                cmd(i2cs_pkg::CMD_START, 8'h00, 1'b0);
                wr(wAdr | 8'h01, 1'b1);
                for (int r = 0; r < 8; r++)
                begin
                    n = expLen(a);
                    w = memWord(a);
                    cmd(i2cs_pkg::CMD_READ, 8'h00, r == 7);
                    check("read", rdData, w[8 * (n - 1 - idx) +: 8]);
                    idx++;
                    if (idx == n)
                    begin
                        idx = 0;
                        a = (a == 12'ha56) ? a : a + 12'h1;
                    end
                end
                stop();
            end
        end
        wrap_up();
    end
endmodule : test_i2c_slave_control_port

`default_nettype wire
